// ---- hw/tmecu_top.sv ----
`timescale 1ns/10ps
// What this block does
// - Every channel counts 16 bits for interval, pulse and group-synchronous work; channels 1, 2, 3, 5, 6, 7 and 9 also count events.
// - Every channel has an up-counter, two buffered compares, two captures and an output flip-flop.
// - Sixteen identical channels run on their own apart from wiring and interrupts.
// - Flip-flops of channels 0, 4, 8 and 12 act as capture triggers for their partner groups.
// - In synchronous mode a follower whose own run bit is set starts only when its group leader's run bit is set.
// - Channels 8 to 15 have no pin output and channels 10 and 11 feed on-chip peripherals.
// - Channels 1, 2, 5, 6, 7, 9 take two inputs, channel 3 counts the serial clock, 5 and 6 feed serial.
// - Each channel owns a 0x100 byte window, channel 0 at the base and channel 15 at base plus 0xf00.
// - With its enable bit low a channel is frozen and only its enable register responds.
// - Clearing the enable bit keeps every setting of the channel.
module tmecu_top #(
  parameter int PRESCALE = tmecu_pkg::PRESCALE_DIV // Internal count tick divider
) (
  input wire logic clk, // System clock
  input wire logic rstn, // Async reset, active low
  input wire logic [tmecu_pkg::AW-1:0] avs_address, // Byte address within block
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  input wire logic [tmecu_pkg::NEXT-1:0] capture_input_first, // First external input pins
  input wire logic [tmecu_pkg::NEXT-1:0] capture_input_second, // Second external input pins
  input wire logic serial_port3_clock, // Serial clock counted by channel 3
  output logic [tmecu_pkg::NPIN-1:0] flipflop_pin_out, // Flip-flop pins, channels 0 to 7
  output logic [1:0] serial_timer_out, // Channels 5 and 6 to serial
  output logic consumer_control_peripheral_out, // Channel 10 flip-flop
  output logic remote_receiver_peripheral_out, // Channel 11 flip-flop
  output logic [tmecu_pkg::NCH-1:0] timer_interrupt_request, // Per-channel timer request
  output logic [tmecu_pkg::NEXT-1:0] capture_interrupt_request_first, // First capture request
  output logic [tmecu_pkg::NEXT-1:0] capture_interrupt_request_second, // Second capture request
  output logic irq // Combined level interrupt
);
  localparam int NC = tmecu_pkg::NCH;
  localparam int NX = tmecu_pkg::NEXT;
  localparam int NI = tmecu_pkg::NIRQ;
  localparam int PDW = (PRESCALE > 1) ? $clog2(PRESCALE) : 1;

  typedef struct packed {
    logic [NC-1:0] en;
    logic [NC-1:0] run;
    logic [NC-1:0] prun;
    logic [NC-1:0] sync;
    logic [NC-1:0] dbuf;
    logic [NC-1:0] clr_match;
    logic [NC-1:0][1:0] clk_sel;
    logic [NC-1:0][1:0] cap_mode;
    logic [NC-1:0][1:0] ff_en;
    logic [NC-1:0][15:0] buf0;
    logic [NC-1:0][15:0] buf1;
    logic [NC-1:0][NI-1:0] ist;
    logic [NC-1:0][NI-1:0] ien;
    logic [NC-1:0] ff_prev;
    logic [NX-1:0][2:0] sy0;
    logic [NX-1:0][2:0] sy1;
    logic [2:0] sy_sclk;
    logic [NX-1:0] lv0;
    logic [NX-1:0] lv1;
    logic lv_sclk;
    logic [PDW-1:0] pdiv;
    logic ack;
    logic [31:0] rdata;
  } tmecu_state_type;

  tmecu_state_type st;
  tmecu_state_type next_st;
  logic [tmecu_pkg::CHW-1:0] ch;
  logic [7:0] off;
  logic [31:0] bem;
  logic [31:0] rmux;
  logic [31:0] wv;
  logic tick;
  logic [NC-1:0] ext0_r;
  logic [NC-1:0] ext0_f;
  logic [NC-1:0] ext1_r;
  logic [NC-1:0] step_v;
  logic [NC-1:0] run_eff;
  logic [NC-1:0] cap0_ev_v;
  logic [NC-1:0] cap1_ev_v;
  logic [NC-1:0] ffset_v;
  logic [NC-1:0] ffclr_v;
  logic [NC-1:0][NI-1:0] iclr_v;
  logic [NC-1:0][15:0] ch_cnt;
  logic [NC-1:0][15:0] ch_cap0;
  logic [NC-1:0][15:0] ch_cap1;
  logic [NC-1:0] ch_ff;
  logic [NC-1:0] ch_m0;
  logic [NC-1:0] ch_m1;
  logic [NC-1:0] ch_ovf;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  assign ch = avs_address[tmecu_pkg::CH_LSB +: tmecu_pkg::CHW];
  assign off = avs_address[7:0];
  assign bem = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign wv = (avs_writedata & bem) | (rmux & ~bem);
  assign tick = (st.pdiv == PDW'(PRESCALE - 1));

  always_comb begin
    logic [3:0] lead;
    logic [3:0] src;
    lead = '0;
    src = '0;
    next_st = st;
    ext0_r = '0;
    ext0_f = '0;
    ext1_r = '0;
    step_v = '0;
    run_eff = '0;
    cap0_ev_v = '0;
    cap1_ev_v = '0;
    ffset_v = '0;
    ffclr_v = '0;
    iclr_v = '0;
    rmux = '0;

    // ----------------------------------------
    // Pin synchronisers and edge detect
    // ----------------------------------------
    for (int k = 0; k < NX; k++) begin
      next_st.sy0[k] = {st.sy0[k][1:0], capture_input_first[k]};
      next_st.sy1[k] = {st.sy1[k][1:0], capture_input_second[k]};
      if (st.sy0[k][1] == st.sy0[k][2]) begin
        next_st.lv0[k] = st.sy0[k][2];
      end
      if (st.sy1[k][1] == st.sy1[k][2]) begin
        next_st.lv1[k] = st.sy1[k][2];
      end
      ext0_r[tmecu_pkg::EXT_CHAN[k]] = next_st.lv0[k] & ~st.lv0[k];
      ext0_f[tmecu_pkg::EXT_CHAN[k]] = ~next_st.lv0[k] & st.lv0[k];
      ext1_r[tmecu_pkg::EXT_CHAN[k]] = next_st.lv1[k] & ~st.lv1[k];
    end
    next_st.sy_sclk = {st.sy_sclk[1:0], serial_port3_clock};
    if (st.sy_sclk[1] == st.sy_sclk[2]) begin
      next_st.lv_sclk = st.sy_sclk[2];
    end
    ext0_r[tmecu_pkg::CH_SCLK] = next_st.lv_sclk & ~st.lv_sclk;
    ext0_f[tmecu_pkg::CH_SCLK] = ~next_st.lv_sclk & st.lv_sclk;
    next_st.pdiv = tick ? '0 : st.pdiv + PDW'(1);
    next_st.ff_prev = ch_ff;

    // ----------------------------------------
    // Register read image
    // ----------------------------------------
    if (off == tmecu_pkg::OFF_EN) begin
      rmux[tmecu_pkg::EN_BIT] = st.en[ch];
    end else if (st.en[ch]) begin
      case (off)
        tmecu_pkg::OFF_RUN: begin
          rmux[tmecu_pkg::RUN_BIT] = st.run[ch];
          rmux[tmecu_pkg::PRUN_BIT] = st.prun[ch];
        end
        tmecu_pkg::OFF_CR: begin
          rmux[tmecu_pkg::SYNC_BIT] = st.sync[ch];
          rmux[tmecu_pkg::DBUF_BIT] = st.dbuf[ch];
        end
        tmecu_pkg::OFF_MOD: begin
          rmux[tmecu_pkg::CLK_LSB +: 2] = st.clk_sel[ch];
          rmux[tmecu_pkg::CLR_BIT] = st.clr_match[ch];
          rmux[tmecu_pkg::CAPM_LSB +: 2] = st.cap_mode[ch];
        end
        tmecu_pkg::OFF_FFCR: begin
          rmux[tmecu_pkg::FFE_LSB +: 2] = st.ff_en[ch];
          rmux[tmecu_pkg::FFVAL_BIT] = ch_ff[ch];
        end
        tmecu_pkg::OFF_IST: rmux[NI-1:0] = st.ist[ch];
        tmecu_pkg::OFF_IEN: rmux[NI-1:0] = st.ien[ch];
        tmecu_pkg::OFF_RG0: rmux[15:0] = st.buf0[ch];
        tmecu_pkg::OFF_RG1: rmux[15:0] = st.buf1[ch];
        tmecu_pkg::OFF_CP0: rmux[15:0] = ch_cap0[ch];
        tmecu_pkg::OFF_CP1: rmux[15:0] = ch_cap1[ch];
        tmecu_pkg::OFF_UC: rmux[15:0] = ch_cnt[ch];
        default: rmux = '0;
      endcase
    end

    // ----------------------------------------
    // Bus slave: one wait state per access
    // ----------------------------------------
    next_st.ack = (avs_read | avs_write) & ~st.ack;
    if (avs_read && !st.ack) begin
      next_st.rdata = rmux;
    end
    if (avs_write && st.ack) begin
      if (off == tmecu_pkg::OFF_EN) begin
        next_st.en[ch] = wv[tmecu_pkg::EN_BIT];
      end else if (st.en[ch]) begin
        case (off)
          tmecu_pkg::OFF_RUN: begin
            next_st.run[ch] = wv[tmecu_pkg::RUN_BIT];
            next_st.prun[ch] = wv[tmecu_pkg::PRUN_BIT];
          end
          tmecu_pkg::OFF_CR: begin
            next_st.sync[ch] = wv[tmecu_pkg::SYNC_BIT];
            next_st.dbuf[ch] = wv[tmecu_pkg::DBUF_BIT];
          end
          tmecu_pkg::OFF_MOD: begin
            next_st.clk_sel[ch] = wv[tmecu_pkg::CLK_LSB +: 2];
            next_st.clr_match[ch] = wv[tmecu_pkg::CLR_BIT];
            next_st.cap_mode[ch] = wv[tmecu_pkg::CAPM_LSB +: 2];
          end
          tmecu_pkg::OFF_FFCR: begin
            next_st.ff_en[ch] = wv[tmecu_pkg::FFE_LSB +: 2];
            ffset_v[ch] = wv[tmecu_pkg::FFSET_BIT];
            ffclr_v[ch] = wv[tmecu_pkg::FFCLR_BIT];
          end
          tmecu_pkg::OFF_ICLR: iclr_v[ch] = wv[NI-1:0];
          tmecu_pkg::OFF_IEN: next_st.ien[ch] = wv[NI-1:0];
          tmecu_pkg::OFF_RG0: next_st.buf0[ch] = wv[15:0];
          tmecu_pkg::OFF_RG1: next_st.buf1[ch] = wv[15:0];
          default: next_st.rdata = st.rdata;
        endcase
      end
    end

    // ----------------------------------------
    // Per-channel sources and interrupt status
    // ----------------------------------------
    for (int c = 0; c < NC; c++) begin
      lead = tmecu_pkg::tmecu_lead(4'(c));
      src = tmecu_pkg::tmecu_src(4'(c));
      run_eff[c] = st.run[c] & (~st.sync[c] | st.run[lead]);
      case (st.clk_sel[c])
        tmecu_pkg::CLK_TICK: step_v[c] = tick & st.prun[c];
        tmecu_pkg::CLK_EXT: step_v[c] = ext0_r[c];
        tmecu_pkg::CLK_SYS: step_v[c] = 1'b1;
        default: step_v[c] = 1'b0;
      endcase
      case (st.cap_mode[c])
        tmecu_pkg::CAP_TWO: begin
          cap0_ev_v[c] = ext0_r[c];
          cap1_ev_v[c] = ext1_r[c];
        end
        tmecu_pkg::CAP_PULSE: begin
          cap0_ev_v[c] = ext0_r[c];
          cap1_ev_v[c] = ext0_f[c];
        end
        tmecu_pkg::CAP_TRIG: begin
          if (src != 4'(c) && lead != 4'(c)) begin
            cap0_ev_v[c] = ch_ff[src] & ~st.ff_prev[src];
            cap1_ev_v[c] = ~ch_ff[src] & st.ff_prev[src];
          end
        end
        default: cap0_ev_v[c] = 1'b0;
      endcase
      // Set wins over a clear in the same cycle
      next_st.ist[c] = (st.ist[c] & ~iclr_v[c]) | ({NI{st.en[c]}} & {
        cap1_ev_v[c] & tmecu_pkg::EXT_MASK[c], cap0_ev_v[c] & tmecu_pkg::EXT_MASK[c],
        ch_ovf[c], ch_m1[c], ch_m0[c]});
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Channel instances
  // ----------------------------------------
  for (genvar g = 0; g < NC; g++) begin : g_ch
    tmecu_chan_if cif();
    assign cif.gate = st.en[g];
    assign cif.run = run_eff[g];
    assign cif.step = step_v[g];
    assign cif.clr_match = st.clr_match[g];
    assign cif.dbuf = st.dbuf[g];
    assign cif.buf0 = st.buf0[g];
    assign cif.buf1 = st.buf1[g];
    assign cif.ff_en = st.ff_en[g];
    assign cif.ff_set = ffset_v[g];
    assign cif.ff_clr = ffclr_v[g];
    assign cif.cap0_ev = cap0_ev_v[g];
    assign cif.cap1_ev = cap1_ev_v[g];
    assign ch_cnt[g] = cif.cnt;
    assign ch_cap0[g] = cif.cap0;
    assign ch_cap1[g] = cif.cap1;
    assign ch_ff[g] = cif.ff;
    assign ch_m0[g] = cif.match0;
    assign ch_m1[g] = cif.match1;
    assign ch_ovf[g] = cif.ovf;
    assign timer_interrupt_request[g] = |(st.ist[g][tmecu_pkg::IRQ_OVF:0] & st.ien[g][tmecu_pkg::IRQ_OVF:0]);
    tmecu_chan u_chan (.clk(clk), .rstn(rstn), .cif(cif));
  end

  for (genvar k = 0; k < NX; k++) begin : g_cap_irq
    assign capture_interrupt_request_first[k] = st.ist[tmecu_pkg::EXT_CHAN[k]][tmecu_pkg::IRQ_CP0] &
      st.ien[tmecu_pkg::EXT_CHAN[k]][tmecu_pkg::IRQ_CP0];
    assign capture_interrupt_request_second[k] = st.ist[tmecu_pkg::EXT_CHAN[k]][tmecu_pkg::IRQ_CP1] &
      st.ien[tmecu_pkg::EXT_CHAN[k]][tmecu_pkg::IRQ_CP1];
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign avs_readdata = st.rdata;
  assign avs_waitrequest = (avs_read | avs_write) & ~st.ack;
  assign flipflop_pin_out = ch_ff[tmecu_pkg::NPIN-1:0];
  assign serial_timer_out = {ch_ff[tmecu_pkg::CH_SER1], ch_ff[tmecu_pkg::CH_SER0]};
  assign consumer_control_peripheral_out = ch_ff[tmecu_pkg::CH_CONSUMER];
  assign remote_receiver_peripheral_out = ch_ff[tmecu_pkg::CH_REMOTE];
  assign irq = |(st.ist & st.ien);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_win_en_write: assert property (
    avs_write && !avs_waitrequest && off == tmecu_pkg::OFF_EN && avs_byteenable[0]
    |=> st.en[$past(ch)] == $past(avs_writedata[tmecu_pkg::EN_BIT]))
    else $error("enable write missed its window");
  a_gate_no_write: assert property (
    avs_write && !avs_waitrequest && off == tmecu_pkg::OFF_RUN && !st.en[ch] |=> $stable(st.run))
    else $error("write reached a disabled channel");
  a_gate_read_zero: assert property (
    avs_read && avs_waitrequest && off != tmecu_pkg::OFF_EN && !st.en[ch] |=> avs_readdata == '0)
    else $error("disabled channel returned data");
  a_hold_config: assert property (
    !st.en[1] |=> $stable(st.buf0[1]) && $stable(ch_cnt[1]) && $stable(st.clk_sel[1]))
    else $error("disabled channel changed state");
  a_count_step: assert property (
    st.en[2] && run_eff[2] && st.clk_sel[2] == tmecu_pkg::CLK_SYS && !(st.clr_match[2] && ch_m1[2])
    |=> ch_cnt[2] == $past(ch_cnt[2]) + 16'h0001)
    else $error("counter did not step");
  a_sync_start: assert property (
    st.en[5] && st.sync[5] && !st.run[4] |=> ch_cnt[5] == '0)
    else $error("group follower ran without its leader");
  a_cross_capture: assert property (
    st.en[5] && st.cap_mode[5] == tmecu_pkg::CAP_TRIG && ch_ff[0] && !st.ff_prev[0]
    |=> ch_cap0[5] == $past(ch_cnt[5]))
    else $error("cross trigger capture missed");
  a_match_toggle: assert property (
    st.en[4] && ch_m0[4] && st.ff_en[4][0] && !(ch_m1[4] && st.ff_en[4][1]) && !ffset_v[4] && !ffclr_v[4]
    |=> ch_ff[4] != $past(ch_ff[4]))
    else $error("flip-flop did not toggle on match");
  a_serial_clock: assert property (
    st.en[3] && run_eff[3] && st.clk_sel[3] == tmecu_pkg::CLK_EXT && ext0_r[3] && !(st.clr_match[3] && ch_m1[3])
    |=> ch_cnt[3] == $past(ch_cnt[3]) + 16'h0001)
    else $error("serial clock edge not counted");
  a_capture_irq: assert property (
    st.en[1] && st.ien[1][tmecu_pkg::IRQ_CP0] && cap0_ev_v[1] |=> capture_interrupt_request_first[0] && irq)
    else $error("capture interrupt not raised");

  c_sync_group: cover property (st.sync[2] && $rose(st.run[0]));
  c_cross_capture: cover property (cap0_ev_v[5] && st.cap_mode[5] == tmecu_pkg::CAP_TRIG);
  c_irq_fire: cover property ($rose(irq));
  c_gated_write: cover property (avs_write && !avs_waitrequest && !st.en[ch] && off != tmecu_pkg::OFF_EN);
endmodule : tmecu_top

// ---- hw/tmecu_pkg.sv ----
package tmecu_pkg;
  // ----------------------------------------
  // Channel array and address window
  // ----------------------------------------
  localparam int NCH = 16;
  localparam logic [31:0] BASE_ADDR = 32'h400d_0000;
  localparam int AW = 12;
  localparam int CH_LSB = 8;
  localparam int CHW = 4;
  localparam int CW = 16;

  // ----------------------------------------
  // Register offsets inside a channel window
  // ----------------------------------------
  localparam logic [7:0] OFF_EN = 8'h00;
  localparam logic [7:0] OFF_RUN = 8'h04;
  localparam logic [7:0] OFF_CR = 8'h08;
  localparam logic [7:0] OFF_MOD = 8'h0c;
  localparam logic [7:0] OFF_FFCR = 8'h10;
  localparam logic [7:0] OFF_IST = 8'h14;
  localparam logic [7:0] OFF_ICLR = 8'h18;
  localparam logic [7:0] OFF_IEN = 8'h1c;
  localparam logic [7:0] OFF_RG0 = 8'h20;
  localparam logic [7:0] OFF_RG1 = 8'h24;
  localparam logic [7:0] OFF_CP0 = 8'h28;
  localparam logic [7:0] OFF_CP1 = 8'h2c;
  localparam logic [7:0] OFF_UC = 8'h30;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int EN_BIT = 7;
  localparam int RUN_BIT = 0;
  localparam int PRUN_BIT = 2;
  localparam int SYNC_BIT = 5;
  localparam int DBUF_BIT = 7;
  localparam int CLK_LSB = 0;
  localparam int CLR_BIT = 2;
  localparam int CAPM_LSB = 3;
  localparam int FFE_LSB = 0;
  localparam int FFSET_BIT = 2;
  localparam int FFCLR_BIT = 3;
  localparam int FFVAL_BIT = 4;
  localparam int NIRQ = 5;
  localparam int IRQ_M0 = 0;
  localparam int IRQ_M1 = 1;
  localparam int IRQ_OVF = 2;
  localparam int IRQ_CP0 = 3;
  localparam int IRQ_CP1 = 4;

  typedef enum logic [1:0] {
    CLK_TICK = 2'h0, CLK_EXT = 2'h1, CLK_SYS = 2'h2, CLK_OFF = 2'h3
  } tmecu_clk_type;
  typedef enum logic [1:0] {
    CAP_OFF = 2'h0, CAP_TWO = 2'h1, CAP_PULSE = 2'h2, CAP_TRIG = 2'h3
  } tmecu_cap_type;

  // ----------------------------------------
  // Channel wiring
  // ----------------------------------------
  localparam int NEXT = 6;
  localparam logic [NEXT-1:0][3:0] EXT_CHAN = {4'h9, 4'h7, 4'h6, 4'h5, 4'h2, 4'h1};
  localparam logic [NCH-1:0] EXT_MASK = 16'h02e6;
  localparam int CH_SCLK = 3;
  localparam int CH_SER0 = 5;
  localparam int CH_SER1 = 6;
  localparam int CH_CONSUMER = 10;
  localparam int CH_REMOTE = 11;
  localparam int NPIN = 8;
  localparam int PRESCALE_DIV = 4;

  function automatic logic [3:0] tmecu_lead(input logic [3:0] c);
    return {c[3:2], 2'b00};
  endfunction : tmecu_lead

  function automatic logic [3:0] tmecu_src(input logic [3:0] c);
    return {c[3:2] ^ 2'b01, 2'b00};
  endfunction : tmecu_src
endpackage : tmecu_pkg

// ---- hw/tmecu_chan_if.sv ----
`timescale 1ns/10ps
interface tmecu_chan_if;
  logic gate;
  logic run;
  logic step;
  logic clr_match;
  logic dbuf;
  logic [15:0] buf0;
  logic [15:0] buf1;
  logic [1:0] ff_en;
  logic ff_set;
  logic ff_clr;
  logic cap0_ev;
  logic cap1_ev;
  logic [15:0] cnt;
  logic [15:0] cap0;
  logic [15:0] cap1;
  logic ff;
  logic match0;
  logic match1;
  logic ovf;
  modport top (output gate, run, step, clr_match, dbuf, buf0, buf1, ff_en, ff_set, ff_clr,
               cap0_ev, cap1_ev, input cnt, cap0, cap1, ff, match0, match1, ovf);
  modport chan (input gate, run, step, clr_match, dbuf, buf0, buf1, ff_en, ff_set, ff_clr,
                cap0_ev, cap1_ev, output cnt, cap0, cap1, ff, match0, match1, ovf);
endinterface : tmecu_chan_if

// ---- hw/tmecu_chan.sv ----
`timescale 1ns/10ps
module tmecu_chan (
  input wire logic clk, // System clock
  input wire logic rstn, // Async reset, active low
  tmecu_chan_if.chan cif // Controls from the register block
);
  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] cmp0;
    logic [15:0] cmp1;
    logic [15:0] cap0;
    logic [15:0] cap1;
    logic ff;
  } tmecu_chan_type;

  tmecu_chan_type st;
  tmecu_chan_type next_st;
  logic live;
  logic hit0;
  logic hit1;
  logic reload;

  // ----------------------------------------
  // Comparators
  // ----------------------------------------
  assign live = cif.gate & cif.run & cif.step;
  assign hit0 = live & (st.cnt == st.cmp0);
  assign hit1 = live & (st.cnt == st.cmp1);
  assign reload = hit1 & cif.clr_match;

  // ----------------------------------------
  // Counter, buffers, captures, flip-flop
  // ----------------------------------------
  always_comb begin
    next_st = st;
    if (cif.gate) begin
      if (!cif.run) begin
        next_st.cnt = '0;
      end else if (cif.step) begin
        next_st.cnt = reload ? '0 : st.cnt + 16'h0001;
      end
      // Double buffer loads on clear-on-match or while stopped
      if (!cif.dbuf || !cif.run || reload) begin
        next_st.cmp0 = cif.buf0;
        next_st.cmp1 = cif.buf1;
      end
      if (cif.cap0_ev) begin
        next_st.cap0 = st.cnt;
      end
      if (cif.cap1_ev) begin
        next_st.cap1 = st.cnt;
      end
      if (cif.ff_set) begin
        next_st.ff = 1'b1;
      end else if (cif.ff_clr) begin
        next_st.ff = 1'b0;
      end else begin
        next_st.ff = st.ff ^ (hit0 & cif.ff_en[0]) ^ (hit1 & cif.ff_en[1]);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cif.cnt = st.cnt;
  assign cif.cap0 = st.cap0;
  assign cif.cap1 = st.cap1;
  assign cif.ff = st.ff;
  assign cif.match0 = hit0;
  assign cif.match1 = hit1;
  assign cif.ovf = live & ~reload & (st.cnt == 16'hffff);
endmodule : tmecu_chan

// ---- verif/tmecu_top_tb.sv ----
`timescale 1ns/10ps
module tmecu_top_tb;
  logic clk;
  logic rstn;
  logic [11:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [5:0] cap_a;
  logic [5:0] cap_b;
  logic [15:0] tirq;
  logic [5:0] cirq_a;
  logic [5:0] cirq_b;
  logic irq;
  logic sclk;
  logic [7:0] ffo;
  logic [1:0] sero;
  logic cons;
  logic remo;
  int mismatches;
  int check_count;
  tmecu_top u_tmecu_top (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .capture_input_first(cap_a),
    .capture_input_second(cap_b), .serial_port3_clock(sclk), .flipflop_pin_out(ffo), .serial_timer_out(sero),
    .consumer_control_peripheral_out(cons), .remote_receiver_peripheral_out(remo), .timer_interrupt_request(tirq),
    .capture_interrupt_request_first(cirq_a), .capture_interrupt_request_second(cirq_b), .irq(irq));
  // ----------------------------------------
  // Bus and judging tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [3:0] c, input logic [7:0] o, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= {c, o};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20) begin
      mismatches++;
      complete_run();
    end
  endtask : bus
  task automatic wr(input logic [3:0] c, input logic [7:0] o, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, c, o, d, q);
  endtask : wr
  task automatic rdc(input logic [3:0] c, input logic [7:0] o, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, c, o, 32'h0, q);
    check(q & m, e);
  endtask : rdc
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_gate();
    wr(4'h3, 8'h0c, 32'h2);
    wr(4'h3, 8'h00, 32'h80);
    rdc(4'h3, 8'h0c, '1, 32'h0);
    wr(4'h3, 8'h08, 32'ha0);
    wr(4'h3, 8'h00, 32'h0);
    rdc(4'h3, 8'h08, '1, 32'h0);
    wr(4'h3, 8'h08, 32'h0);
    wr(4'h3, 8'h00, 32'h80);
    rdc(4'h3, 8'h08, '1, 32'ha0);
  endtask : s_gate
  task automatic s_window();
    for (int c = 0; c < 16; c++) begin
      rdc(c[3:0], 8'h00, '1, (c == 3) ? 32'h80 : 32'h0);
      wr(c[3:0], 8'h00, 32'hffff_ffff);
      wr(c[3:0], 8'h20, {24'h0, c[3:0], 4'ha});
    end
    for (int c = 0; c < 16; c++) begin
      rdc(c[3:0], 8'h00, '1, 32'h80);
      rdc(c[3:0], 8'h20, '1, {24'h0, c[3:0], 4'ha});
    end
    rdc(4'h0, 8'h40, '1, 32'h0);
  endtask : s_window
  task automatic s_irq();
    wr(4'h2, 8'h0c, 32'h2);
    wr(4'h2, 8'h20, 32'h10);
    wr(4'h2, 8'h24, 32'hffff);
    wr(4'h2, 8'h1c, 32'h1);
    wr(4'h2, 8'h04, 32'h1);
    repeat (40) @(posedge clk);
    rdc(4'h2, 8'h14, 32'h1, 32'h1);
    check(32'(tirq), 32'h4);
    check(32'(irq), 32'h1);
    wr(4'h2, 8'h1c, 32'h0);
    @(posedge clk);
    check(32'(irq), 32'h0);
    wr(4'h2, 8'h04, 32'h0);
    wr(4'h2, 8'h18, 32'h1f);
    wr(4'h2, 8'h1c, 32'h1);
    rdc(4'h2, 8'h14, '1, 32'h0);
    check(32'(irq), 32'h0);
  endtask : s_irq
  task automatic s_sync();
    logic [31:0] a;
    logic [31:0] b;
    wr(4'h5, 8'h08, 32'h20);
    wr(4'h5, 8'h0c, 32'h2);
    wr(4'h5, 8'h04, 32'h1);
    rdc(4'h5, 8'h30, '1, 32'h0);
    wr(4'h4, 8'h0c, 32'h2);
    wr(4'h4, 8'h04, 32'h1);
    bus(1'b0, 4'h5, 8'h30, 32'h0, a);
    bus(1'b0, 4'h4, 8'h30, 32'h0, b);
    check(b - a, 32'h3);
  endtask : s_sync
  task automatic s_capture();
    logic [31:0] a;
    logic [31:0] b;
    wr(4'h1, 8'h0c, 32'h0a);
    wr(4'h1, 8'h1c, 32'h18);
    wr(4'h1, 8'h04, 32'h1);
    @(posedge clk);
    cap_a <= 6'h1;
    cap_b <= 6'h1;
    repeat (12) @(posedge clk);
    check({cirq_b, cirq_a}, 32'h41);
    rdc(4'h1, 8'h14, 32'h18, 32'h18);
    bus(1'b0, 4'h1, 8'h28, 32'h0, a);
    bus(1'b0, 4'h1, 8'h2c, 32'h0, b);
    check(b, a);
    check(32'(a != 0), 32'h1);
  endtask : s_capture
  task automatic s_serial();
    wr(4'h3, 8'h08, 32'h0);
    wr(4'h3, 8'h0c, 32'h1);
    wr(4'h3, 8'h04, 32'h1);
    repeat (4) begin
      sclk <= 1'b1;
      repeat (6) @(posedge clk);
      sclk <= 1'b0;
      repeat (6) @(posedge clk);
    end
    rdc(4'h3, 8'h30, '1, 32'h4);
  endtask : s_serial
  task automatic s_cross();
    wr(4'h5, 8'h0c, 32'h1a);
    wr(4'h0, 8'h10, 32'h4);
    @(posedge clk);
    check(32'(ffo), 32'h1);
    rdc(4'h5, 8'h14, 32'h8, 32'h8);
    wr(4'h5, 8'h10, 32'h4);
    @(posedge clk);
    check(32'(sero), 32'h1);
    wr(4'ha, 8'h10, 32'h4);
    @(posedge clk);
    check(32'({cons, remo}), 32'h2);
    wr(4'hb, 8'h10, 32'h4);
    @(posedge clk);
    check(32'({cons, remo}), 32'h3);
    check(32'(ffo), 32'h21);
    wr(4'h4, 8'h10, 32'h1);
    wr(4'h4, 8'h04, 32'h0);
    wr(4'h4, 8'h04, 32'h1);
    repeat (100) @(posedge clk);
    check(32'(ffo), 32'h31);
  endtask : s_cross
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rstn = 1'b0;
    {avs_address, avs_read, avs_write, avs_writedata, cap_a, cap_b, sclk} = '0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    s_gate();
    s_window();
    s_irq();
    s_sync();
    s_capture();
    s_serial();
    s_cross();
    complete_run();
  end
endmodule : tmecu_top_tb
